// ### inc/rci_pkg.sv
package rci_pkg;
	localparam int CLK_PERIOD_NS   = 10;
	localparam int HOLD_MAX_NS     = 20_000_000;
	localparam int HOLD_CYC        = HOLD_MAX_NS / CLK_PERIOD_NS;
	localparam int RX_BUF_CHARS    = 1000;
	localparam int RX_FIFO_DEPTH   = 32;
	localparam int REPLY_MAX_CHARS = 1000;
	localparam int ITEM_CHARS      = 13;
	localparam int MAX_ITEMS       = (REPLY_MAX_CHARS - 1) / ITEM_CHARS;

	localparam logic [6:0] CH_LF    = 7'h0A;
	localparam logic [6:0] CH_CR    = 7'h0D;
	localparam logic [6:0] CH_SP    = 7'h20;
	localparam logic [6:0] CH_PLUS  = 7'h2B;
	localparam logic [6:0] CH_COMMA = 7'h2C;
	localparam logic [6:0] CH_MINUS = 7'h2D;
	localparam logic [6:0] CH_DOT   = 7'h2E;
	localparam logic [6:0] CH_SLASH = 7'h2F;
	localparam logic [6:0] CH_0     = 7'h30;
	localparam logic [6:0] CH_COLON = 7'h3A;
	localparam logic [6:0] CH_SEMI  = 7'h3B;
	localparam logic [6:0] CH_E     = 7'h65;
	localparam logic [6:0] CH_LO_A  = 7'h61;
	localparam logic [6:0] CH_LO_Z  = 7'h7A;
	localparam logic [6:0] CH_DEL   = 7'h7F;
	localparam logic [6:0] CASE_OFS = 7'h20;
	localparam logic [34:0] READ_KEY = {7'h52, 7'h45, 7'h41, 7'h44, 7'h3D};
	localparam logic [2:0]  READ_LEN = 3'h5;

	localparam logic [3:0] FI_SIGN = 4'h1;
	localparam logic [3:0] FI_MANT = 4'h2;
	localparam logic [3:0] FI_EXP  = 4'h9;
	localparam logic [3:0] FI_ESGN = 4'hA;
	localparam logic [3:0] FI_EDIG = 4'hB;
	localparam logic [3:0] FI_SEP  = 4'hC;
	localparam logic [3:0] FI_LF   = 4'hD;
	localparam logic [2:0] DP_MAX  = 3'h6;

	typedef enum logic [1:0] {TOK_CHAR, TOK_ITEM_SEP, TOK_CMD_END, TOK_STR_END} tok_e;
endpackage

// ### inc/rci_if.sv
interface stream_if #(parameter int W = 8);
	logic [W-1:0] data;
	logic         valid;
	logic         ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

interface ram_if #(parameter int AW = 10, parameter int W = 7);
	logic          we;
	logic [AW-1:0] waddr;
	logic [AW-1:0] raddr;
	logic [W-1:0]  wdata;
	logic [W-1:0]  rdata;
	modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ### src/line_ram.sv
module line_ram #(
	parameter int W     = 7,
	parameter int DEPTH = 1000,
	parameter int AW    = 10
) (
	input logic   sys_clk_i,
	ram_if.mem    port
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [W-1:0]            rdata;
	} ram_s;

	ram_s q;
	ram_s next;

	always_comb begin
		next = q;
		if (port.we && port.waddr < AW'(DEPTH)) begin
			next.mem[port.waddr] = port.wdata;
		end
		next.rdata = (port.raddr < AW'(DEPTH)) ? q.mem[port.raddr] : '0;
	end

	// storage only, so no reset: contents are invalid until written
	always_ff @(posedge sys_clk_i) begin
		q <= next;
	end

	assign port.rdata = q.rdata;
endmodule

// ### src/cmd_fifo.sv
module cmd_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 32,
	parameter int AW    = $clog2(DEPTH)
) (
	input  logic        sys_clk_i,
	input  logic        srst_i,
	stream_if.snk       in_s,
	stream_if.src       out_s,
	output logic [AW:0] level_o
);
	// pointers wrap naturally, so DEPTH must be a power of two
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} fifo_s;

	fifo_s q;
	fifo_s next;
	logic  push;
	logic  pop;

	always_comb begin
		next = q;
		push = in_s.valid && in_s.ready;
		pop  = out_s.valid && out_s.ready;
		if (push) begin
			next.mem[q.wp] = in_s.data;
			next.wp        = q.wp + 1'b1;
		end
		if (pop) begin
			next.rp = q.rp + 1'b1;
		end
		if (push && !pop) begin
			next.cnt = q.cnt + 1'b1;
		end else if (pop && !push) begin
			next.cnt = q.cnt - 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			q <= '0;
		end else begin
			q <= next;
		end
	end

	assign in_s.ready  = q.cnt != (AW+1)'(DEPTH);
	assign out_s.valid = q.cnt != '0;
	assign out_s.data  = q.mem[q.rp];
	assign level_o     = q.cnt;

	no_overrun_a: assert property (@(posedge sys_clk_i) disable iff (srst_i)
		in_s.valid |-> in_s.ready) else $error("fifo written while full");
	fifo_full_c: cover property (@(posedge sys_clk_i) disable iff (srst_i)
		q.cnt == (AW+1)'(DEPTH));
endmodule

// ### src/remote_command_interface.sv
module remote_command_interface
	import rci_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = HOLD_CYC,
	parameter int          FIFO_DEPTH  = RX_FIFO_DEPTH
) (
	input  logic        sys_clk_i,
	input  logic        srst_i,
	input  logic        serial_i,
	input  logic [4:0]  my_addr_i,
	input  logic        addr_valid_i,
	input  logic [4:0]  addr_i,
	input  logic        addr_talk_i,
	input  logic        addr_sec_i,
	input  logic        ren_i,
	input  logic        gtl_i,
	input  logic        local_key_i,
	input  logic        dev_clear_i,
	input  logic        ifc_i,
	input  logic        hs_abort_i,
	input  logic        get_i,
	input  logic        rx_valid_i,
	input  logic [7:0]  rx_data_i,
	input  logic        rx_eoi_i,
	output logic        rx_ready_o,
	output logic        tok_valid_o,
	output logic [6:0]  tok_char_o,
	output tok_e        tok_kind_o,
	input  logic        reply_arm_i,
	input  logic [6:0]  reply_items_i,
	output logic        item_req_o,
	output logic [6:0]  item_idx_o,
	input  logic        item_valid_i,
	input  logic        item_neg_i,
	input  logic [23:0] item_mant_i,
	input  logic [2:0]  item_dp_i,
	input  logic        item_exp_neg_i,
	input  logic [3:0]  item_exp_i,
	output logic        tx_valid_o,
	output logic [6:0]  tx_data_o,
	output logic        tx_eoi_o,
	input  logic        tx_ready_i,
	output logic        remote_o,
	output logic        listen_o,
	output logic        talk_o
);
	localparam int LW = $clog2(FIFO_DEPTH) + 1;

	typedef enum logic {S_FILL, S_SCAN} st_e;

	typedef struct packed {
		st_e         st;
		logic [9:0]  len;
		logic        ovf;
		logic [9:0]  rptr;
		logic        pend;
		logic [2:0]  pos;
		logic        rmatch;
		logic        in_read;
		logic        tok_valid;
		logic [6:0]  tok_char;
		tok_e        tok_kind;
		logic        listen;
		logic        talk;
		logic        remote;
		logic        armed;
		logic [6:0]  items;
		logic [6:0]  idx;
		logic [3:0]  fi;
		logic        have;
		logic        req;
		logic        neg;
		logic [23:0] mant;
		logic [2:0]  dp;
		logic        eneg;
		logic [3:0]  edig;
		logic        tx_valid;
		logic [6:0]  tx_data;
		logic        tx_eoi;
		logic [6:0]  last_sent;
		logic [31:0] hold;
		logic        flush;
		logic        rx_ready;
	} st_s;

	st_s           q;
	st_s           next;
	logic          clr_req;
	logic          go;
	logic          last;
	logic          term;
	logic          accept;
	logic [6:0]    ch;
	logic [LW-1:0] fifo_level;

	stream_if #(.W(8))         fin ();
	stream_if #(.W(8))         fout ();
	ram_if #(.AW(10), .W(7))   ram ();

	function automatic logic [6:0] upcase(input logic [6:0] c);
		upcase = (c >= CH_LO_A && c <= CH_LO_Z) ? c - CASE_OFS : c;
	endfunction

	function automatic logic is_skip(input logic [6:0] c);
		is_skip = (c <= CH_SP) || (c == CH_DEL);
	endfunction

	function automatic logic [6:0] key_char(input logic [2:0] p);
		key_char = READ_KEY[7*(4 - int'(p)) +: 7];
	endfunction

	// one character of a numeric item: " +123.456e+3" then separator
	function automatic logic [6:0] fmt_char(input st_s s, input logic lst);
		logic [3:0] p;
		logic [3:0] d;
		logic [6:0] c;
		p = s.fi - FI_MANT;
		d = (p < {1'b0, s.dp}) ? p : p - 4'h1;
		c = CH_SP;
		if (s.fi == FI_SIGN) begin
			c = s.neg ? CH_MINUS : CH_PLUS;
		end else if (s.fi >= FI_MANT && s.fi < FI_EXP) begin
			c = (p == {1'b0, s.dp}) ? CH_DOT : CH_0 | {3'h0, s.mant[4*(5 - int'(d)) +: 4]};
		end else if (s.fi == FI_EXP) begin
			c = CH_E;
		end else if (s.fi == FI_ESGN) begin
			c = s.eneg ? CH_MINUS : CH_PLUS;
		end else if (s.fi == FI_EDIG) begin
			c = CH_0 | {3'h0, s.edig};
		end else if (s.fi == FI_SEP) begin
			c = lst ? CH_CR : CH_COMMA;
		end else if (s.fi == FI_LF) begin
			c = CH_LF;
		end
		fmt_char = c;
	endfunction

	cmd_fifo #(
		.W     (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i (sys_clk_i),
		.srst_i    (srst_i || q.flush),
		.in_s      (fin.snk),
		.out_s     (fout.src),
		.level_o   (fifo_level)
	);

	line_ram #(
		.W     (7),
		.DEPTH (RX_BUF_CHARS),
		.AW    (10)
	) u_ram (
		.sys_clk_i (sys_clk_i),
		.port      (ram.mem)
	);

	// receive side: gpib listens only while remote, serial always
	assign accept = serial_i || (q.remote && q.listen);
	assign term   = get_i || (rx_valid_i && (rx_eoi_i || rx_data_i[6:0] == CH_LF));
	assign fin.valid = (rx_valid_i || get_i) && q.rx_ready && accept;
	assign fin.data  = {term, rx_valid_i ? rx_data_i[6:0] : 7'h00};
	assign fout.ready = q.st == S_FILL;

	always_comb begin
		next         = q;
		go           = serial_i || q.talk;
		last         = (q.idx + 7'h01) == q.items;
		ch           = upcase(ram.rdata);
		ram.we       = 1'b0;
		ram.waddr    = q.len;
		ram.wdata    = fout.data[6:0];
		ram.raddr    = q.rptr;
		next.tok_valid = 1'b0;
		next.flush     = 1'b0;
		next.rx_ready  = fifo_level < LW'(FIFO_DEPTH - 1);

		// collect characters; nothing is decoded before a terminator
		if (q.st == S_FILL && fout.valid) begin
			if (!q.ovf && q.len < 10'(RX_BUF_CHARS)) begin
				ram.we   = 1'b1;
				next.len = q.len + 10'h001;
			end else begin
				next.ovf = 1'b1;
			end
			if (fout.data[7]) begin
				next.st      = S_SCAN;
				next.rptr    = '0;
				next.pend    = 1'b0;
				next.ovf     = 1'b0;
				next.pos     = '0;
				next.rmatch  = 1'b1;
				next.in_read = 1'b0;
			end
		end

		// walk the stored string in order, so later commands override earlier
		if (q.st == S_SCAN) begin
			next.pend = q.rptr < q.len;
			if (q.rptr < q.len) begin
				next.rptr = q.rptr + 10'h001;
			end
			if (q.pend && !is_skip(ch)) begin
				next.tok_valid = 1'b1;
				next.tok_char  = ch;
				if (ch == CH_COMMA || ch == CH_SEMI) begin
					next.tok_kind = TOK_CMD_END;
					next.pos      = '0;
					next.rmatch   = 1'b1;
					next.in_read  = 1'b0;
				end else if (ch == CH_COLON || (ch == CH_SLASH && !q.in_read)) begin
					next.tok_kind = TOK_ITEM_SEP;
				end else begin
					next.tok_kind = TOK_CHAR;
					if (!q.in_read && q.pos < READ_LEN) begin
						next.rmatch = q.rmatch && ch == key_char(q.pos);
						next.pos    = q.pos + 3'h1;
						next.in_read = (q.pos == READ_LEN - 3'h1) && next.rmatch;
					end
				end
			end else if (!q.pend && q.rptr == q.len) begin
				next.tok_valid = 1'b1;
				next.tok_char  = CH_LF;
				next.tok_kind  = TOK_STR_END;
				next.st        = S_FILL;
				next.len       = '0;
			end
		end

		// addressing: primary only; no poll, service request or 488.2 paths
		if (addr_valid_i && !addr_sec_i) begin
			if (addr_i == my_addr_i) begin
				if (addr_talk_i) begin
					next.talk = 1'b1;
				end else begin
					next.listen = 1'b1;
					next.remote = ren_i;
				end
			end else if (addr_talk_i) begin
				next.talk = 1'b0;
			end
		end
		if (gtl_i || local_key_i || !ren_i) begin
			next.remote = 1'b0;
		end

		// reply engine
		if (reply_arm_i) begin
			next.armed    = 1'b1;
			next.items    = (reply_items_i == 7'h00) ? 7'h01 :
				(reply_items_i > 7'(MAX_ITEMS)) ? 7'(MAX_ITEMS) : reply_items_i;
			next.idx      = '0;
			next.fi       = '0;
			next.have     = 1'b0;
			next.req      = 1'b0;
			next.tx_valid = 1'b0;
		end else if (q.armed && go) begin
			if (!q.have && !q.req) begin
				next.req = 1'b1;
			end
			if (q.req && item_valid_i) begin
				next.req  = 1'b0;
				next.have = 1'b1;
				next.fi   = '0;
				next.neg  = item_neg_i;
				next.mant = item_mant_i;
				next.dp   = (item_dp_i > DP_MAX) ? DP_MAX : item_dp_i;
				next.eneg = item_exp_neg_i;
				next.edig = item_exp_i;
			end
			if (q.tx_valid && tx_ready_i) begin
				next.tx_valid  = 1'b0;
				next.last_sent = q.tx_data;
				if (q.fi == (last ? FI_LF : FI_SEP)) begin
					next.have = 1'b0;
					next.fi   = '0;
					if (last) begin
						next.idx   = '0;
						next.armed = !serial_i;
					end else begin
						next.idx = q.idx + 7'h01;
					end
				end else begin
					next.fi = q.fi + 4'h1;
				end
			end else if (q.have && !q.tx_valid) begin
				next.tx_valid = 1'b1;
				next.tx_data  = fmt_char(q, last);
				next.tx_eoi   = q.fi == FI_LF;
			end
		end

		// a stalled receive handshake, or an item request while serial or talking, may never outlast the hold limit
		if ((rx_valid_i && !q.rx_ready) || (q.req && go)) begin
			next.hold = q.hold + 32'h0000_0001;
		end else begin
			next.hold = '0;
		end

		// clears and broken handshakes restart everything from power-on state
		clr_req = dev_clear_i || ifc_i || hs_abort_i || q.hold >= HOLD_CYCLES;
		if (clr_req) begin
			next       = '0;
			next.flush = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			q <= '0;
		end else begin
			q <= next;
		end
	end

	assign rx_ready_o  = q.rx_ready;
	assign tok_valid_o = q.tok_valid;
	assign tok_char_o  = q.tok_char;
	assign tok_kind_o  = q.tok_kind;
	assign item_req_o  = q.req;
	assign item_idx_o  = q.idx;
	assign tx_valid_o  = q.tx_valid;
	assign tx_data_o   = q.tx_data;
	assign tx_eoi_o    = q.tx_eoi;
	assign remote_o    = q.remote;
	assign listen_o    = q.listen;
	assign talk_o      = q.talk;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (srst_i);

	reply_end_a: assert property (tx_valid_o && tx_eoi_o |->
		tx_data_o == CH_LF && q.last_sent == CH_CR) else $error("reply end not CR LF EOI");
	term_scan_a: assert property (q.st == S_FILL && fout.valid && fout.data[7] && !clr_req
		|=> q.st == S_SCAN) else $error("terminator did not start decode");
	no_secondary_a: assert property (addr_valid_i && addr_sec_i && !clr_req
		|=> $stable(listen_o) && $stable(talk_o)) else $error("secondary address acted");
	hold_bound_a: assert property (q.hold <= HOLD_CYCLES)
		else $error("handshake held past limit");
	reply_cap_a: assert property (q.items <= 7'(MAX_ITEMS))
		else $error("reply longer than limit");
	serial_once_a: assert property (serial_i && q.tx_valid && tx_ready_i && q.tx_eoi
		&& !reply_arm_i && !clr_req |=> !q.armed) else $error("serial reply repeated");
	stall_read_a: assert property (item_req_o && !item_valid_i && go && !reply_arm_i
		&& !clr_req |=> item_req_o && !tx_valid_o) else $error("read not stalled");
	gpib_repeat_a: assert property (!serial_i && q.tx_valid && tx_ready_i && q.tx_eoi
		&& !reply_arm_i && !clr_req |=> q.armed && q.idx == 7'h00) else $error("reply not rereadable");
	decode_late_a: assert property (tok_valid_o |-> $past(q.st) == S_SCAN)
		else $error("token before terminator");
	read_colon_a: assert property (tok_valid_o && tok_kind_o == TOK_ITEM_SEP && q.in_read
		|-> tok_char_o == CH_COLON) else $error("slash split a read command");
	clean_char_a: assert property (tok_valid_o && tok_kind_o == TOK_CHAR |->
		!is_skip(tok_char_o) && !(tok_char_o inside {[CH_LO_A:CH_LO_Z]}))
		else $error("raw character passed");
	remote_entry_a: assert property (addr_valid_i && !addr_sec_i && !addr_talk_i
		&& addr_i == my_addr_i && ren_i && !gtl_i && !local_key_i && !clr_req
		|=> remote_o && listen_o) else $error("listen address did not go remote");
	stay_listen_a: assert property (listen_o && !clr_req |=> listen_o)
		else $error("device unaddressed itself");
	overflow_keep_a: assert property (q.st == S_FILL && q.len == 10'(RX_BUF_CHARS) && !clr_req
		|=> q.len == 10'(RX_BUF_CHARS)) else $error("overflow disturbed buffer");
	clear_reset_a: assert property (dev_clear_i |=> !remote_o && !listen_o && !tx_valid_o)
		else $error("clear did not reset");

	reply_done_c: cover property (tx_valid_o && tx_ready_i && tx_eoi_o);
	read_cmd_c: cover property (q.in_read && tok_valid_o && tok_kind_o == TOK_ITEM_SEP);
	overflow_c: cover property (q.ovf);
	multi_cmd_c: cover property (tok_valid_o && tok_kind_o == TOK_CMD_END);
endmodule

// ### sim/host_model.sv
module host_model (
	input  logic       sys_clk_i,
	input  logic       stall_i,
	input  logic       rx_ready_i,
	output logic       rx_valid_o,
	output logic [7:0] rx_data_o,
	output logic       rx_eoi_o,
	output logic       get_o,
	output logic       tx_ready_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o  = 8'h55;
		rx_eoi_o   = 1'b0;
		get_o      = 1'b0;
		tx_ready_o = 1'b1;
	end
	// slow reader holds the reply off at random
	always @(negedge sys_clk_i) tx_ready_o <= !stall_i || $urandom_range(2) == 0;
	// held until the edge that takes it, so back to back chars need no gap
	task automatic send_char(input logic [7:0] c, input logic eoi, input logic get, output bit ok);
		ok = 1'b0;
		@(negedge sys_clk_i);
		rx_data_o  = c;
		rx_eoi_o   = eoi;
		rx_valid_o = !get;
		get_o      = get;
		for (int n = 0; n < 5000 && !ok; n++) begin
			@(posedge sys_clk_i);
			ok = rx_ready_i === 1'b1;
		end
	endtask
	// inverse data after release so a stale value never passes
	task automatic release_rx;
		@(negedge sys_clk_i);
		rx_valid_o = 1'b0;
		get_o      = 1'b0;
		rx_eoi_o   = 1'b0;
		rx_data_o  = ~rx_data_o;
	endtask
endmodule

// ### sim/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import rci_pkg::*;

	logic        sys_clk_i = 1'b0;
	logic        srst_i    = 1'b1;
	logic        serial_i, addr_valid_i, addr_talk_i, addr_sec_i, ren_i, reply_arm_i;
	logic        gtl_i, local_key_i, dev_clear_i, ifc_i, hs_abort_i, stall;
	logic        item_valid_i, item_neg_i, item_exp_neg_i, prov_en;
	logic [4:0]  my_addr_i, addr_i;
	logic [6:0]  reply_items_i;
	logic [23:0] item_mant_i;
	logic [2:0]  item_dp_i;
	logic [3:0]  item_exp_i;
	logic        rx_valid_i, rx_eoi_i, get_i, rx_ready_o, tok_valid_o, item_req_o;
	logic        tx_valid_o, tx_eoi_o, tx_ready_i, remote_o, listen_o, talk_o;
	logic [7:0]  rx_data_i;
	logic [6:0]  tok_char_o, item_idx_o, tx_data_o;
	tok_e        tok_kind_o;
	int          err_count   = 0;
	int          comparisons = 0;
	int          n_eff, answered;
	logic [8:0]  tq[$];
	logic [7:0]  xq[$];

	remote_command_interface #(.HOLD_CYCLES(200)) DUT (
		.sys_clk_i, .srst_i, .serial_i, .my_addr_i, .addr_valid_i, .addr_i, .addr_talk_i,
		.addr_sec_i, .ren_i, .gtl_i, .local_key_i, .dev_clear_i, .ifc_i, .hs_abort_i,
		.get_i, .rx_valid_i, .rx_data_i, .rx_eoi_i, .rx_ready_o, .tok_valid_o, .tok_char_o,
		.tok_kind_o, .reply_arm_i, .reply_items_i, .item_req_o, .item_idx_o, .item_valid_i,
		.item_neg_i, .item_mant_i, .item_dp_i, .item_exp_neg_i, .item_exp_i, .tx_valid_o,
		.tx_data_o, .tx_eoi_o, .tx_ready_i, .remote_o, .listen_o, .talk_o
	);
	host_model host (
		.sys_clk_i, .stall_i(stall), .rx_ready_i(rx_ready_o), .rx_valid_o(rx_valid_i),
		.rx_data_o(rx_data_i), .rx_eoi_o(rx_eoi_i), .get_o(get_i), .tx_ready_o(tx_ready_i)
	);

	initial forever #5 sys_clk_i = ~sys_clk_i;

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic to(string what);
		err_count++;
		$display("FAIL %s expected done seen timeout", what);
		test_done();
	endtask

	always @(posedge sys_clk_i) if (tok_valid_o === 1'b1) begin
		if (tq.size() == 0) chk("spare token", 0, 1);
		else chk("token", tq.pop_front(), {tok_kind_o, tok_char_o});
	end
	always @(posedge sys_clk_i) if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
		if (xq.size() == 0) chk("spare reply char", 0, 1);
		else chk("reply char", xq.pop_front(), {tx_eoi_o, tx_data_o});
	end

	task automatic push_tok(string s);
		string      key = "READ=";
		logic [7:0] c;
		int         k   = 0;
		bit         m   = 1'b1;
		foreach (s[i]) begin
			c = s[i];
			if (c >= 8'h61 && c <= 8'h7A) c = c - 8'h20;
			if (c <= 8'h20 || c == 8'h7F) continue;
			if (c == 8'h2C || c == 8'h3B) begin
				tq.push_back({TOK_CMD_END, c[6:0]});
				k = 0;
				m = 1'b1;
			end else if (c == 8'h3A || (c == 8'h2F && !(m && k >= 5))) begin
				tq.push_back({TOK_ITEM_SEP, c[6:0]});
			end else begin
				tq.push_back({TOK_CHAR, c[6:0]});
				if (k < 5 && c != key[k]) m = 1'b0;
				k++;
			end
		end
		tq.push_back({TOK_STR_END, CH_LF});
	endtask

	task automatic push_item(int idx);
		int dpc;
		dpc = item_dp_i > 6 ? 6 : int'(item_dp_i);
		xq.push_back({1'b0, CH_SP});
		xq.push_back({1'b0, item_neg_i ? CH_MINUS : CH_PLUS});
		for (int k = 0; k < 6; k++) begin
			if (k == dpc) xq.push_back({1'b0, CH_DOT});
			xq.push_back({1'b0, CH_0 + 7'(item_mant_i[23 - 4 * k -: 4])});
		end
		if (dpc == 6) xq.push_back({1'b0, CH_DOT});
		xq.push_back({1'b0, CH_E});
		xq.push_back({1'b0, item_exp_neg_i ? CH_MINUS : CH_PLUS});
		xq.push_back({1'b0, CH_0 + 7'(item_exp_i)});
		if (idx == n_eff - 1) begin
			xq.push_back({1'b0, CH_CR});
			xq.push_back({1'b1, CH_LF});
		end else xq.push_back({1'b0, CH_COMMA});
	endtask

	// measurement side answers each item request while prov_en is set, after a random delay of 0 to 4 cycles
	initial forever begin
		@(negedge sys_clk_i);
		if (item_req_o === 1'b1 && prov_en) begin
			repeat ($urandom_range(4)) @(negedge sys_clk_i);
			item_neg_i = 1'($urandom);
			item_dp_i = 3'($urandom);
			item_exp_neg_i = 1'($urandom);
			item_exp_i = 4'($urandom_range(9));
			for (int d = 0; d < 6; d++) item_mant_i[4 * d +: 4] = 4'($urandom_range(9));
			item_valid_i = 1'b1;
			push_item(item_idx_o);
			answered++;
			@(negedge sys_clk_i);
			item_valid_i = 1'b0;
		end
	end

	// keep is the count of chars the parser should see, 0 when dropped
	task automatic send(string s, int term, int keep);
		bit ok;
		int k;
		for (k = 0; k < 3000 && tq.size() > 0; k++) @(negedge sys_clk_i);
		for (int i = 0; i < s.len() - (term == 1); i++) begin
			host.send_char(s[i], 1'b0, 1'b0, ok);
			if (!ok) to("char taken");
		end
		host.release_rx();
		repeat (20) @(negedge sys_clk_i);
		if (keep > 0) push_tok(s.substr(0, keep - 1));
		host.send_char(term == 0 ? 8'h0A : s[s.len() - 1], term == 1, term == 2, ok);
		if (!ok) to("terminator taken");
		host.release_rx();
	endtask

	task automatic adr(logic [4:0] a, logic talk, logic sec);
		@(negedge sys_clk_i);
		addr_valid_i = 1'b1;
		addr_i = a;
		addr_talk_i = talk;
		addr_sec_i = sec;
		@(negedge sys_clk_i);
		addr_valid_i = 1'b0;
		addr_i = ~a;
		@(negedge sys_clk_i);
	endtask

	task automatic pulse(int w);
		@(negedge sys_clk_i);
		{hs_abort_i, ifc_i, dev_clear_i, local_key_i, gtl_i} = 5'(1 << w);
		@(negedge sys_clk_i);
		{hs_abort_i, ifc_i, dev_clear_i, local_key_i, gtl_i} = 5'h00;
		@(negedge sys_clk_i);
	endtask

	task automatic arm(int n);
		n_eff = n == 0 ? 1 : (n > MAX_ITEMS ? MAX_ITEMS : n);
		answered = 0;
		@(negedge sys_clk_i);
		reply_arm_i = 1'b1;
		reply_items_i = 7'(n);
		@(negedge sys_clk_i);
		reply_arm_i = 1'b0;
	endtask

	task automatic rep(int n, int want);
		int k;
		arm(n);
		if (want == 0) want = n_eff;
		for (k = 0; k < 30000 && answered < want; k++) @(negedge sys_clk_i);
		if (answered < want) to("reply items");
	endtask

	initial begin
		repeat (100000) @(posedge sys_clk_i);
		to("run length");
	end

	initial begin
		string s;
		int    k;
		int    nl[3] = '{0, 3, 100};
		{serial_i, addr_valid_i, addr_talk_i, addr_sec_i, ren_i, reply_arm_i} = 6'h00;
		{gtl_i, local_key_i, dev_clear_i, ifc_i, hs_abort_i, stall} = 6'h00;
		{item_valid_i, item_neg_i, item_exp_neg_i, prov_en} = 4'h1;
		{my_addr_i, addr_i, reply_items_i, item_dp_i, item_exp_i} = 24'h00_0000;
		item_mant_i = 24'h00_0000;
		my_addr_i = 5'h0B;
		void'($urandom(96839));
		repeat (16) @(negedge sys_clk_i);
		srst_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
		send("abc", 0, 0);
		chk("remote in local", 0, remote_o);
		adr(my_addr_i, 1'b0, 1'b1);
		chk("listen on secondary", 0, listen_o);
		ren_i = 1'b1;
		adr(my_addr_i, 1'b0, 1'b0);
		chk("remote when addressed", 1, remote_o);
		adr(5'h03, 1'b0, 1'b0);
		chk("listen kept", 1, listen_o);
		$display("test addressing done");
		s = "set a:b/c; read=x:y/z ,\tq\177";
		send(s, 0, s.len());
		send("mode=A;Mode=b", 1, 13);
		send("x:1/2", 2, 5);
		chk("remote after transfer", 1, remote_o);
		$display("test parsing done");
		s = "";
		repeat (1020) s = {s, "a"};
		// letters up to the cut, with spaces at 990 to 994, so the 1000th char is seen exactly
		foreach (s[i]) begin
			s[i] = 8'h41 + 8'($urandom_range(25)) + 8'h20 * 8'($urandom_range(1));
			if (i >= 990 && i < 995) s[i] = 8'h20;
		end
		send(s, 0, 1000);
		send("ok", 0, 2);
		$display("test overflow done");
		for (int w = 0; w < 2; w++) begin
			pulse(w);
			chk("remote after local", 0, remote_o);
			send("lost", 0, 0);
			adr(my_addr_i, 1'b0, 1'b0);
			chk("remote after readdress", 1, remote_o);
		end
		$display("test local done");
		stall = 1'b1;
		adr(my_addr_i, 1'b1, 1'b0);
		chk("talk", 1, talk_o);
		rep(2, 4);
		// starve the item source so the reply parks between items, not mid-char
		prov_en = 1'b0;
		repeat (4) @(negedge sys_clk_i);
		for (k = 0; k < 3000 && item_req_o !== 1'b1; k++) @(negedge sys_clk_i);
		if (item_req_o !== 1'b1) to("reread idle");
		chk("reread drained", 0, xq.size());
		adr(5'h03, 1'b1, 1'b0);
		chk("talk dropped", 0, talk_o);
		repeat (300) @(negedge sys_clk_i);
		xq.delete();
		$display("test reread done");
		adr(my_addr_i, 1'b1, 1'b0);
		prov_en = 1'b0;
		arm(1);
		for (k = 0; k < 400 && talk_o !== 1'b0; k++) @(negedge sys_clk_i);
		chk("hold limit", 1, k > 190 && k < 215);
		prov_en = 1'b1;
		$display("test watchdog done");
		for (int w = 2; w < 5; w++) begin
			adr(my_addr_i, 1'b0, 1'b0);
			pulse(w);
			chk("cleared", 0, {remote_o, listen_o, talk_o});
			repeat (4) @(negedge sys_clk_i);
			chk("ready after clear", 1, rx_ready_o);
		end
		$display("test clear done");
		serial_i = 1'b1;
		srst_i = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		srst_i = 1'b0;
		repeat (2) @(negedge sys_clk_i);
		send("q;r", 0, 3);
		foreach (nl[j]) begin
			rep(nl[j], 0);
			for (k = 0; k < 3000 && xq.size() > 0; k++) @(negedge sys_clk_i);
			repeat (100) @(negedge sys_clk_i);
			chk("items once", n_eff, answered);
			chk("reply drained", 0, xq.size());
		end
		$display("test serial done");
		chk("tokens left", 0, tq.size());
		test_done();
	end
endmodule
